//--- verilog/relay_out_pkg.sv
// package for the relay output function logic: codes, reset values, timing, field structs
// assumes a 50 MHz system clock; times are held in 10 ms ticks, levels in 0.01 % or 0.1 %
package relay_out_pkg;

  // ****************************************************************
  // clock and time base
  // ****************************************************************
  localparam int CLK_HZ = 50_000_000;
  localparam int TICK_MS = 10;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

  // ****************************************************************
  // function codes
  // ****************************************************************
  localparam logic [7:0] IN_FUNC_TIMER = 8'h26;    // 38
  localparam logic [7:0] OUT_ITEM_ONOFF = 8'h18;   // 24
  localparam logic [7:0] OUT_ITEM_TIMER = 8'h1c;   // 28
  localparam logic [7:0] OUT_ITEM_BRAKE = 8'h23;   // 35

  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_IN_FUNC = 8'h04;
  localparam logic [7:0] OFS_OUT_ITEM = 8'h08;
  localparam logic [7:0] OFS_TIMER_DLY = 8'h0c;
  localparam logic [7:0] OFS_BRK_CUR = 8'h10;
  localparam logic [7:0] OFS_BRK_TIME = 8'h14;
  localparam logic [7:0] OFS_BRK_FREQ = 8'h18;
  localparam logic [7:0] OFS_ENG_FREQ = 8'h1c;
  localparam logic [7:0] OFS_CMP_LVL = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;

  // ****************************************************************
  // reset values (times in 10 ms ticks, levels in 0.01 %, current 0.1 %)
  // ****************************************************************
  localparam logic [15:0] RST_ON_DLY = 16'h012c;   // 3.00 s
  localparam logic [15:0] RST_OFF_DLY = 16'h0064;  // 1.00 s
  localparam logic [15:0] RST_REL_CUR = 16'h01f4;  // 50.0 %
  localparam logic [15:0] RST_REL_TIME = 16'h0064; // 1.00 s
  localparam logic [15:0] RST_ENG_TIME = 16'h0064; // 1.00 s
  localparam logic [15:0] RST_REL_FREQ = 16'h0064; // 1.00 Hz
  localparam logic [15:0] RST_ENG_FREQ = 16'h0064; // 1.00 Hz
  localparam logic [15:0] RST_ON_LVL = 16'h2328;   // 90.00 %
  localparam logic [15:0] RST_OFF_LVL = 16'h0000;
  localparam logic [1:0] RST_CMP_SRC = 2'h1;       // first voltage input
  localparam logic [15:0] MAX_LVL = 16'h2710;      // 100.00 %
  localparam logic [15:0] MAX_CUR = 16'h0708;      // 180.0 %
  localparam logic [15:0] MAX_TMR = 16'h2710;      // 100.00 s
  localparam logic [15:0] MAX_BRK_TIME = 16'h03e8; // 10.00 s

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [2:0] {
    BRK_IDLE = 3'b000,
    BRK_ACCEL = 3'b001,
    BRK_RELHOLD = 3'b011,
    BRK_RUN = 3'b010,
    BRK_DECEL = 3'b110,
    BRK_ENGHOLD = 3'b111,
    BRK_DCB = 3'b101
  } brk_state_t;

  // drive-side request to the frequency generator
  typedef struct packed {
    logic hold_freq;     // freeze ramp
    logic force_zero;    // output frequency to zero
    logic dcb_start;     // request dc braking
    logic out_block;     // inverter output blocked
    logic dcb_start_dis; // start dc braking suppressed
    logic dwell_dis;     // dwell suppressed
  } drive_ctl_t;

endpackage

//--- verilog/relay_out_logic.sv
// relay output function logic: timer, brake sequencer, analog on/off comparator
// assumes a frequency/current feed from the drive core on aclk and AXI4-Lite software access
// Functional notes
// - input terminal with function code 38 becomes the timer trigger
// - output with item code 28 follows the delayed timer output
// - timer output asserts after trigger stays on for the on-delay, default 3.00 s
// - timer output drops after trigger stays off for the off-delay, default 1.00 s
// - brake control enabled suppresses start dc braking and dwell
// - run from idle accelerates only up to direction-matched release frequency; a restart from dc braking keeps the direction latched in idle
// - at release frequency and current threshold, brake release asserts
// - after release, hold frequency for release delay, then resume acceleration
// - on stop, decelerate to engage frequency, halt ramp, assert brake engage
// - after engage, hold frequency for engage delay, then frequency zero
// - with dc braking enabled (control bit 1), request dc braking and block output together
// - output with item code 35 carries the brake release signal
// - selectable analog source for the comparator, default first voltage input
// - on level default 90.00 %, off level not above on level
// - output with item code 24 follows the comparator result
`timescale 1ns/1ns
module relay_out_logic
  import relay_out_pkg::*;
#(
  parameter int N_IN = 5,
  parameter int N_OUT = 2,
  parameter int TICK = relay_out_pkg::TICK_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pins and drive core
  input wire logic [N_IN-1:0] term_in,
  input wire logic run_cmd,
  input wire logic run_rev,
  input wire logic [15:0] out_freq,
  input wire logic [15:0] motor_current,
  input wire logic [15:0] analog_in [4],
  output relay_out_pkg::drive_ctl_t drive_ctl,
  output logic [N_OUT-1:0] relay_out
);
  import relay_out_pkg::*;

  // ****************************************************************
  // registers
  // ****************************************************************
  logic brk_en_r, dcb_cfg_r;
  logic [1:0] cmp_src_r;
  logic [7:0] in_func_r [N_IN];
  logic [7:0] out_item_r [N_OUT];
  logic [15:0] on_dly_r, off_dly_r, rel_cur_r, rel_time_r, eng_time_r;
  logic [15:0] rel_fwd_r, rel_rev_r, eng_freq_r, on_lvl_r, off_lvl_r;
  logic aw_done_r, w_done_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;

  // write channel: address and data latched in either order
  assign s_axi_awready = !aw_done_r && !s_axi_bvalid;
  assign s_axi_wready = !w_done_r && !s_axi_bvalid;
  logic [3:0] wstrb_r;
  wire do_wr = aw_done_r && w_done_r && !s_axi_bvalid;
  wire full_word = &wstrb_r;
  wire [15:0] wlo = wdata_r[15:0];
  wire [15:0] whi = wdata_r[31:16];
  wire wr_map = (awaddr_r <= OFS_STATUS) && (awaddr_r[1:0] == 2'h0);
  wire rd_map = (s_axi_araddr <= OFS_STATUS) && (s_axi_araddr[1:0] == 2'h0);
  wire lvl_ok = (whi <= MAX_LVL) && (wlo <= whi);

  // write handshake bookkeeping
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_done_r <= 1'b0;
      w_done_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_done_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_done_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_map ? 2'h0 : 2'h2; // slverr on unmapped
        aw_done_r <= 1'b0;
        w_done_r <= 1'b0;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // configuration fields; only full-word writes take, out-of-range times and current are clipped, invalid level pairs are ignored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      brk_en_r <= 1'b0;
      dcb_cfg_r <= 1'b0;
      cmp_src_r <= RST_CMP_SRC;
      on_dly_r <= RST_ON_DLY;
      off_dly_r <= RST_OFF_DLY;
      rel_cur_r <= RST_REL_CUR;
      rel_time_r <= RST_REL_TIME;
      eng_time_r <= RST_ENG_TIME;
      rel_fwd_r <= RST_REL_FREQ;
      rel_rev_r <= RST_REL_FREQ;
      eng_freq_r <= RST_ENG_FREQ;
      on_lvl_r <= RST_ON_LVL;
      off_lvl_r <= RST_OFF_LVL;
    end else if (do_wr && full_word) begin
      unique case (awaddr_r)
        OFS_CTRL: begin
          brk_en_r <= wdata_r[0];
          dcb_cfg_r <= wdata_r[1];
          cmp_src_r <= wdata_r[5:4];
        end
        OFS_TIMER_DLY: begin
          on_dly_r <= (wlo > MAX_TMR) ? MAX_TMR : wlo;
          off_dly_r <= (whi > MAX_TMR) ? MAX_TMR : whi;
        end
        OFS_BRK_CUR: rel_cur_r <= (wlo > MAX_CUR) ? MAX_CUR : wlo;
        OFS_BRK_TIME: begin
          rel_time_r <= (wlo > MAX_BRK_TIME) ? MAX_BRK_TIME : wlo;
          eng_time_r <= (whi > MAX_BRK_TIME) ? MAX_BRK_TIME : whi;
        end
        OFS_BRK_FREQ: begin
          rel_fwd_r <= wlo;
          rel_rev_r <= whi;
        end
        OFS_ENG_FREQ: eng_freq_r <= wlo;
        OFS_CMP_LVL: begin
          if (lvl_ok) begin
            off_lvl_r <= wlo;
            on_lvl_r <= whi;
          end
        end
        default: ;
      endcase
    end
  end

  // function select bytes, one per terminal
  genvar gi;
  generate
    for (gi = 0; gi < N_IN; gi++) begin : g_in_func
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          in_func_r[gi] <= 8'h00;
        end else if (do_wr && wstrb_r[gi % 4] && (gi < 4) && awaddr_r == OFS_IN_FUNC) begin
          in_func_r[gi] <= wdata_r[8*(gi%4) +: 8];
        end
      end
    end
    for (gi = 0; gi < N_OUT; gi++) begin : g_out_item
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          out_item_r[gi] <= 8'h00;
        end else if (do_wr && wstrb_r[gi] && awaddr_r == OFS_OUT_ITEM) begin
          out_item_r[gi] <= wdata_r[8*gi +: 8];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // input synchronisers and timer trigger
  // ****************************************************************
  logic [N_IN-1:0] in_s1_r, in_s2_r, in_s3_r, in_q_r;
  logic [N_IN-1:0] trig_sel;
  // a change counts once stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_s1_r <= '0;
      in_s2_r <= '0;
      in_s3_r <= '0;
      in_q_r <= '0;
    end else begin
      in_s1_r <= term_in;
      in_s2_r <= in_s1_r;
      in_s3_r <= in_s2_r;
      in_q_r <= (in_s2_r & in_s3_r) | (in_q_r & (in_s2_r | in_s3_r));
    end
  end
  generate
    for (gi = 0; gi < N_IN; gi++) begin : g_trig
      assign trig_sel[gi] = in_q_r[gi] && (in_func_r[gi] == IN_FUNC_TIMER);
    end
  endgenerate
  wire trig = |trig_sel;

  // ****************************************************************
  // 10 ms tick and on/off delay timer
  // ****************************************************************
  logic [$clog2(TICK)-1:0] tick_cnt_r;
  wire tick = (tick_cnt_r == $bits(tick_cnt_r)'(TICK - 1));
  logic timer_out_r;
  logic [15:0] tmr_cnt_r;
  // shared slow time base keeps every delay counter 16 bits wide
  always_ff @(posedge aclk) begin
    if (!aresetn) tick_cnt_r <= '0;
    else tick_cnt_r <= tick ? '0 : tick_cnt_r + 1'b1;
  end

  wire [15:0] tmr_goal = trig ? on_dly_r : off_dly_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_out_r <= 1'b0;
      tmr_cnt_r <= 16'h0000;
    end else if (trig == timer_out_r) begin
      tmr_cnt_r <= 16'h0000; // glitch shorter than the delay restarts it
    end else if (tmr_cnt_r >= tmr_goal) begin
      timer_out_r <= trig;
      tmr_cnt_r <= 16'h0000;
    end else if (tick) begin
      tmr_cnt_r <= tmr_cnt_r + 16'h0001;
    end
  end

  // ****************************************************************
  // brake sequencer
  // ****************************************************************
  brk_state_t st_r, st_nxt;
  logic [15:0] brk_cnt_r;
  logic brk_rel_r;
  logic dir_rev_r;
  wire [15:0] rel_freq = dir_rev_r ? rel_rev_r : rel_fwd_r;
  wire at_rel = out_freq >= rel_freq;
  wire cur_ok = motor_current >= rel_cur_r;
  wire rel_done = brk_cnt_r >= rel_time_r;
  wire eng_done = brk_cnt_r >= eng_time_r;

  // sequencer next state
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      BRK_IDLE: if (brk_en_r && run_cmd) st_nxt = BRK_ACCEL;
      BRK_ACCEL: if (!run_cmd) st_nxt = BRK_IDLE;
        else if (at_rel && cur_ok) st_nxt = BRK_RELHOLD;
      BRK_RELHOLD: if (rel_done) st_nxt = BRK_RUN;
      BRK_RUN: if (!run_cmd) st_nxt = BRK_DECEL;
      BRK_DECEL: if (out_freq <= eng_freq_r) st_nxt = BRK_ENGHOLD;
      // hold, then zero or dc brake
      BRK_ENGHOLD: if (eng_done) st_nxt = dcb_cfg_r ? BRK_DCB : BRK_IDLE;
      BRK_DCB: if (run_cmd) st_nxt = BRK_ACCEL;
      default: st_nxt = BRK_IDLE;
    endcase
  end

  // state, hold timer and release flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= BRK_IDLE;
      brk_cnt_r <= 16'h0000;
      brk_rel_r <= 1'b0;
      dir_rev_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      brk_cnt_r <= (st_nxt != st_r) ? 16'h0000 : brk_cnt_r + {15'h0000, tick};
      if (st_r == BRK_IDLE) dir_rev_r <= run_rev; // direction latched while idle
      brk_rel_r <= (st_nxt == BRK_RELHOLD) || (st_nxt == BRK_RUN) || (st_nxt == BRK_DECEL);
    end
  end

  // requests to the frequency generator
  always_comb begin
    drive_ctl = '0;
    // suppress start dc brake and dwell
    drive_ctl.dcb_start_dis = brk_en_r;
    drive_ctl.dwell_dis = brk_en_r;
    drive_ctl.hold_freq = (st_r == BRK_ACCEL && at_rel) || (st_r == BRK_RELHOLD)
      || (st_r == BRK_ENGHOLD);
    drive_ctl.force_zero = (st_r == BRK_DCB) || (brk_en_r && st_r == BRK_IDLE && !run_cmd);
    drive_ctl.dcb_start = (st_r == BRK_DCB);
    drive_ctl.out_block = (st_r == BRK_DCB);
  end

  // ****************************************************************
  // analog on/off comparator
  // ****************************************************************
  logic cmp_r;
  wire [15:0] ain = analog_in[cmp_src_r];
  always_ff @(posedge aclk) begin
    if (!aresetn) cmp_r <= 1'b0;
    else if (ain >= on_lvl_r) cmp_r <= 1'b1;
    else if (ain <= off_lvl_r) cmp_r <= 1'b0;
  end

  // ****************************************************************
  // output routing
  // ****************************************************************
  function automatic logic route(input logic [7:0] item, input logic t, input logic b,
    input logic c);
    route = (item == OUT_ITEM_TIMER) ? t : (item == OUT_ITEM_BRAKE) ? b
      : (item == OUT_ITEM_ONOFF) ? c : 1'b0;
  endfunction
  generate
    for (gi = 0; gi < N_OUT; gi++) begin : g_route
      always_ff @(posedge aclk) begin
        if (!aresetn) relay_out[gi] <= 1'b0;
        else relay_out[gi] <= route(out_item_r[gi], timer_out_r, brk_rel_r, cmp_r);
      end
    end
  endgenerate

  // ****************************************************************
  // read channel, one cycle answer
  // ****************************************************************
  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (s_axi_araddr)
      OFS_CTRL: rd_word = {26'h0, cmp_src_r, 2'h0, dcb_cfg_r, brk_en_r};
      OFS_IN_FUNC: for (int k = 0; k < N_IN && k < 4; k++) rd_word[8*k +: 8] = in_func_r[k];
      OFS_OUT_ITEM: for (int k = 0; k < N_OUT; k++) rd_word[8*k +: 8] = out_item_r[k];
      OFS_TIMER_DLY: rd_word = {off_dly_r, on_dly_r};
      OFS_BRK_CUR: rd_word = {16'h0, rel_cur_r};
      OFS_BRK_TIME: rd_word = {eng_time_r, rel_time_r};
      OFS_BRK_FREQ: rd_word = {rel_rev_r, rel_fwd_r};
      OFS_ENG_FREQ: rd_word = {16'h0, eng_freq_r};
      OFS_CMP_LVL: rd_word = {on_lvl_r, off_lvl_r};
      OFS_STATUS: rd_word = {20'h0, st_r, cmp_r, brk_rel_r, timer_out_r, trig, 5'h0};
      default: rd_word = 32'h0000_0000;
    endcase
  end
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_map ? 2'h0 : 2'h2;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

//--- test/relay_out_props.sv
// concurrent checks on the ports of the relay output function logic
// assumes one clock aclk and a synchronous active-low aresetn
`timescale 1ns/1ns
module relay_out_props
  import relay_out_pkg::*;
#(
  parameter int N_OUT = 2
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire relay_out_pkg::drive_ctl_t drive_ctl,
  input wire logic [N_OUT-1:0] relay_out
);
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // address and data taken at one edge
  sequence wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  rst_clear_a: assert property ($rose(aresetn) |->
    relay_out == '0 && !s_axi_bvalid && !s_axi_rvalid && drive_ctl == '0)
    else $error("outputs not clear after reset");
  wr_answer_a: assert property (wr_both |-> ##2 s_axi_bvalid)
    else $error("write response late");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  rd_answer_a: assert property (rd_take |=> s_axi_rvalid)
    else $error("read response late");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  aw_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  ar_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while response pending");
  brake_suppress_a: assert property (drive_ctl.dcb_start_dis == drive_ctl.dwell_dis)
    else $error("start braking and dwell suppression differ");
endmodule
bind relay_out_logic relay_out_props #(.N_OUT(N_OUT)) props_u (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .drive_ctl(drive_ctl), .relay_out(relay_out));

//--- test/brake_load_model.sv
// drive core and load model: ramps the output frequency and reports motor current
// assumes drive_ctl from the block on aclk; the brake itself is passive here
`timescale 1ns/1ns
module brake_load_model
  import relay_out_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run_cmd,
  input wire relay_out_pkg::drive_ctl_t drive_ctl,
  output logic [15:0] out_freq,
  output logic [15:0] motor_current
);
  // ****************************************************************
  // frequency ramp
  // ****************************************************************
  localparam logic [15:0] STEP = 16'h0004;
  localparam logic [15:0] TOP = 16'h0400;
  logic [15:0] freq_r;
  logic [15:0] freq_nxt;
  logic [15:0] up_nxt;
  logic [15:0] dn_nxt;
  // coarse step keeps the run short; the hold lands within one step of a target
  assign up_nxt = (freq_r < TOP) ? freq_r + STEP : freq_r;
  assign dn_nxt = (freq_r > STEP) ? freq_r - STEP : 16'h0000;
  assign freq_nxt = drive_ctl.force_zero ? 16'h0000 : drive_ctl.hold_freq ? freq_r :
    run_cmd ? up_nxt : dn_nxt;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      freq_r <= 16'h0000;
    end else begin
      freq_r <= freq_nxt;
    end
  end
  // load current above the default release threshold while running
  assign motor_current = run_cmd ? 16'h0258 : 16'h0000;
  assign out_freq = freq_r;
endmodule

//--- test/tb_relay_output_function_logic.sv
// testbench: register access over axi4-lite, timer, comparator and brake sequence
// assumes the load model drives frequency and current back into the block
`timescale 1ns/1ns
module tb_relay_output_function_logic;
  import relay_out_pkg::*;
  logic aclk = 0, aresetn = 0, run_cmd = 0, run_rev = 0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [4:0] term_in = '0;
  logic [15:0] out_freq, motor_current, rel;
  logic [15:0] analog_in [4] = '{16'h0, 16'h0, 16'h0, 16'h0};
  logic [15:0] lv [5] = '{16'h1388, 16'h1770, 16'h1388, 16'h0fa0, 16'h1388};
  logic ex [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
  drive_ctl_t drive_ctl;
  logic [1:0] relay_out;
  int errors = 0, tests_run = 0, n, i, d;
  always #10 aclk = ~aclk;
  relay_out_logic #(.N_IN(5), .N_OUT(2), .TICK(10)) dut_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .term_in(term_in),
    .run_cmd(run_cmd), .run_rev(run_rev), .out_freq(out_freq), .motor_current(motor_current),
    .analog_in(analog_in), .drive_ctl(drive_ctl), .relay_out(relay_out));
  brake_load_model load_u (.aclk(aclk), .aresetn(aresetn), .run_cmd(run_cmd),
    .drive_ctl(drive_ctl), .out_freq(out_freq), .motor_current(motor_current));
  // ****************************************************************
  // tasks
  // ****************************************************************
  task summarize();
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task chk_bit(input string nm, input logic e, input logic g);
    chk_val(nm, {31'h0, e}, {31'h0, g});
  endtask
  task wait_cyc(input int c);
    repeat (c) @(posedge aclk);
  endtask
  // each channel released at its own handshake; response waited for without a bound
  task axi_wr(input logic [7:0] a, input logic [31:0] dt, input logic [1:0] er);
    logic aw_done, w_done;
    aw_done = 0;
    w_done = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= dt;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin aw_done = 1; s_axi_awvalid <= 0; end
      if (s_axi_wvalid && s_axi_wready) begin w_done = 1; s_axi_wvalid <= 0; end
    end
    // bready one edge late so the slave must hold its response
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    s_axi_bready <= 1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 0;
    chk_val("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    @(posedge aclk);
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    // rready one edge late so the held read data is exercised
    @(posedge aclk);
    s_axi_rready <= 1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 0;
    chk_val("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    chk_val("rdata", ed, s_axi_rdata);
    @(posedge aclk);
  endtask
  // ****************************************************************
  // sequence
  // ****************************************************************
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    summarize();
  end
  initial begin
    wait_cyc(20);
    aresetn <= 1;
    @(posedge aclk);
    rd_chk(OFS_CTRL, {26'h0, RST_CMP_SRC, 4'h0}, 2'b00);
    rd_chk(OFS_TIMER_DLY, {RST_OFF_DLY, RST_ON_DLY}, 2'b00);
    rd_chk(OFS_BRK_CUR, {16'h0, RST_REL_CUR}, 2'b00);
    rd_chk(OFS_CMP_LVL, {RST_ON_LVL, RST_OFF_LVL}, 2'b00);
    rd_chk(8'h40, 32'h0, 2'b10);
    axi_wr(8'h40, 32'hffffffff, 2'b10);
    chk_bit("no_suppress", 0, drive_ctl.dwell_dis);
    axi_wr(OFS_TIMER_DLY, 32'h00020003, 2'b00);
    axi_wr(OFS_IN_FUNC, 32'h00000026, 2'b00);
    axi_wr(OFS_OUT_ITEM, 32'h0000181c, 2'b00);
    axi_wr(OFS_CMP_LVL, 32'h17700fa0, 2'b00);
    axi_wr(OFS_CMP_LVL, 32'h01000200, 2'b00);
    axi_wr(OFS_CMP_LVL, 32'h27110000, 2'b00);
    rd_chk(OFS_CMP_LVL, 32'h17700fa0, 2'b00);
    // timer: a terminal without the timer code must not trigger
    term_in <= 5'h02;
    wait_cyc(50);
    chk_bit("timer_other", 0, relay_out[0]);
    term_in <= 5'h01;
    wait_cyc(20);
    chk_bit("timer_early", 0, relay_out[0]);
    wait_cyc(30);
    chk_bit("timer_on", 1, relay_out[0]);
    term_in <= 5'h00;
    wait_cyc(10);
    chk_bit("timer_hold", 1, relay_out[0]);
    wait_cyc(30);
    chk_bit("timer_off", 0, relay_out[0]);
    // comparator on the default source, then on the third input
    for (i = 0; i < 5; i++) begin
      analog_in[1] <= lv[i];
      wait_cyc(6);
      chk_bit("cmp_out", ex[i], relay_out[1]);
    end
    analog_in[2] <= 16'h2000;
    axi_wr(OFS_CTRL, 32'h00000020, 2'b00);
    wait_cyc(6);
    chk_bit("cmp_src", 1, relay_out[1]);
    // brake sequence forward, then reverse with dc braking configured
    axi_wr(OFS_OUT_ITEM, 32'h0000231c, 2'b00);
    axi_wr(OFS_BRK_TIME, 32'h00020002, 2'b00);
    axi_wr(OFS_BRK_FREQ, 32'h00c80064, 2'b00);
    for (d = 0; d < 2; d++) begin
      rel = d ? 16'h00c8 : 16'h0064;
      axi_wr(OFS_CTRL, d ? 32'h3 : 32'h1, 2'b00);
      chk_bit("suppress", 1, drive_ctl.dcb_start_dis && drive_ctl.dwell_dis);
      run_rev <= d[0];
      run_cmd <= 1;
      for (n = 0; n < 3000 && relay_out[1] !== 1'b1; n++) @(posedge aclk);
      chk_bit("rel_freq", 1, out_freq >= rel && out_freq <= rel + 16'h10);
      chk_bit("rel_hold", 1, drive_ctl.hold_freq);
      wait_cyc(40);
      chk_bit("rel_resume", 1, !drive_ctl.hold_freq && out_freq > rel);
      wait_cyc(100);
      run_cmd <= 0;
      for (n = 0; n < 3000 && relay_out[1] === 1'b1; n++) @(posedge aclk);
      chk_bit("eng_freq", 1, drive_ctl.hold_freq && out_freq <= 16'h0064);
      wait_cyc(10);
      chk_bit("eng_hold", 0, drive_ctl.force_zero);
      for (n = 0; n < 60 && drive_ctl.force_zero !== 1'b1; n++) @(posedge aclk);
      chk_bit("eng_zero", 1, drive_ctl.force_zero);
      for (n = 0; n < 3000 && d == 1 && drive_ctl.out_block !== 1'b1; n++) @(posedge aclk);
      if (d == 1) chk_bit("dcb_block", 1, drive_ctl.out_block);
      if (d == 1) chk_bit("dcb_start", 1, drive_ctl.dcb_start);
      wait_cyc(50);
    end
    summarize();
  end
endmodule
